// *** adc_serial_framing.sv ***
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module adc_serial_framing
  import serial_framing_pkg::*;
#(
  parameter int CH = CHANNELS
)
(
  // system
  input  wire logic                       sys_clk,
  input  wire logic                       nrst,
  input  wire logic                       clk_en,
  // software register port
  input  wire logic [3:0]                 reg_addr,
  input  wire logic [15:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [15:0]                reg_rdata,
  // bit clock domain (link)
  input  wire logic                       link_clk,
  input  wire logic                       sample_clock_in,
  input  wire logic [CH*SAMPLE_BITS-1:0]  sample_in,
  output logic      [CH-1:0]              lane_a_out,
  output logic      [CH-1:0]              lane_b_out,
  output logic      [CH-1:0]              lane_b_enable,
  output logic                            frame_start_out,
  output logic                            serial_bit_clock_out,
  // serial config port
  input  wire logic                       programming_style_select,
  input  wire logic                       cfg_cs_n,
  input  wire logic                       cfg_sck,
  input  wire logic                       config_serial_in,
  output logic                            config_readback_out,
  output logic                            config_readback_oe
);

  // system domain: config and port
  logic [4:0]  cfg_reg;
  logic [4:0]  cfg_next;
  logic [15:0] reg_rdata_next;
  logic [2:0]  sck_sync_reg;
  logic [1:0]  cs_sync_reg;
  logic [1:0]  sdi_sync_reg;
  logic [1:0]  pss_sync_reg;
  logic [CFG_SHIFT_BITS-1:0] shift_reg;
  logic [2:0]  shift_cnt_reg;
  logic        readback_reg;
  logic        readback_oe_reg;
  logic [1:0]  frame_cnt_sync_reg;
  cfg_type     cfg_s;

  wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
  wire sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
  wire cs_act   = ~cs_sync_reg[1] & ~pss_sync_reg[1];
  wire ser_done = sck_rise & cs_act & (shift_cnt_reg == 3'h7);

  assign cfg_s.two_lane   = cfg_reg[CFG_TWO_LANE_BIT];
  assign cfg_s.twos_comp  = cfg_reg[CFG_TWOS_BIT];
  assign cfg_s.dcs_enable = cfg_reg[CFG_DCS_BIT];
  assign cfg_s.ser_mode   = cfg_reg[CFG_MODE_LSB +: 2];

  wire [CFG_SHIFT_BITS-1:0] shifted = {shift_reg[CFG_SHIFT_BITS-2:0], sdi_sync_reg[1]};
  wire wr_cfg = reg_wr & (reg_addr == OFS_CONFIG);

  assign cfg_next = wr_cfg   ? reg_wdata[4:0] :
                    ser_done ? shifted[4:0]   : cfg_reg;

  assign reg_rdata_next = (reg_addr == OFS_CONFIG) ? {11'h000, cfg_reg} :
                          (reg_addr == OFS_STATUS) ? {14'h0000, frame_cnt_sync_reg} :
                          16'h0000;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_reg         <= CFG_RESET;
      reg_rdata       <= 16'h0000;
      sck_sync_reg    <= 3'h0;
      cs_sync_reg     <= 2'h3;
      sdi_sync_reg    <= 2'h0;
      pss_sync_reg    <= 2'h3;
      shift_reg       <= '0;
      shift_cnt_reg   <= 3'h0;
      readback_reg    <= 1'b0;
      readback_oe_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      sck_sync_reg <= {sck_sync_reg[1:0], cfg_sck};
      cs_sync_reg  <= {cs_sync_reg[0], cfg_cs_n};
      sdi_sync_reg <= {sdi_sync_reg[0], config_serial_in};
      pss_sync_reg <= {pss_sync_reg[0], programming_style_select};
      cfg_reg      <= cfg_next;
      reg_rdata    <= reg_rd ? reg_rdata_next : 16'h0000;
      if (!cs_act)
      begin
        shift_cnt_reg <= 3'h0;
        shift_reg     <= {3'h0, cfg_reg};
      end
      else if (sck_rise)
      begin
        shift_reg     <= shifted;
        shift_cnt_reg <= shift_cnt_reg + 3'h1;
      end
      if (cs_act && sck_fall)
      begin
        readback_reg    <= 1'b0;
        readback_oe_reg <= ~shift_reg[CFG_SHIFT_BITS-1];
      end
      else if (!cs_act)
        readback_oe_reg <= 1'b0;
    end
  end

  assign config_readback_out = readback_reg;
  assign config_readback_oe  = readback_oe_reg;

  // link domain: serializer
  logic [4:0]  cfg_l1_reg;
  logic [4:0]  cfg_l2_reg;
  logic [1:0]  enc_sync_reg;
  logic        enc_prev_reg;
  logic [CH*SAMPLE_BITS-1:0] pipe_reg [PIPE_LATENCY];
  logic [CH*MAX_WORD_BITS-1:0] word_reg;
  logic [4:0]  bit_cnt_reg;
  logic        odd_reg;
  logic [1:0]  frame_cnt_reg;
  logic [1:0]  frame_gray_reg;
  logic [1:0]  frame_gray_s1_reg;
  logic [1:0]  frame_gray_s2_reg;

  wire two_lane_l = cfg_l2_reg[CFG_TWO_LANE_BIT];
  wire twos_l     = cfg_l2_reg[CFG_TWOS_BIT];
  wire [1:0] mode_l = cfg_l2_reg[CFG_MODE_LSB +: 2];
  wire enc_rise = enc_sync_reg[1] & ~enc_prev_reg;
  wire [4:0] word_bits = (mode_l == ser_16_type_val) ? 5'd16 :
                         (mode_l == ser_14_type_val) ? 5'd14 : 5'd12;
  wire [4:0] lane_bits = two_lane_l ? {1'b0, word_bits[4:1]} : word_bits;
  // frame spans two samples in 14-bit two-lane
  wire frame_pair = two_lane_l & (mode_l == ser_14_type_val);

  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_l1_reg    <= CFG_RESET;
      cfg_l2_reg    <= CFG_RESET;
      enc_sync_reg  <= 2'h0;
      enc_prev_reg  <= 1'b0;
      word_reg      <= '0;
      bit_cnt_reg   <= 5'h0;
      odd_reg       <= 1'b0;
      frame_cnt_reg <= 2'h0;
      frame_gray_reg <= 2'h0;
      lane_a_out    <= '0;
      lane_b_out    <= '0;
      lane_b_enable <= '0;
      frame_start_out      <= 1'b0;
      serial_bit_clock_out <= 1'b0;
      for (int i = 0; i < PIPE_LATENCY; i++)
        pipe_reg[i] <= '0;
    end
    else if (clk_en)
    begin
      cfg_l1_reg   <= cfg_reg;
      cfg_l2_reg   <= cfg_l1_reg;
      enc_sync_reg <= {enc_sync_reg[0], sample_clock_in};
      enc_prev_reg <= enc_sync_reg[1];
      serial_bit_clock_out <= ~serial_bit_clock_out;
      // second lane off in one-lane mode
      lane_b_enable <= {CH{two_lane_l}};
      if (enc_rise)
      begin
        pipe_reg[0] <= sample_in;
        for (int i = 1; i < PIPE_LATENCY; i++)
          pipe_reg[i] <= pipe_reg[i-1];
        for (int c = 0; c < CH; c++)
          word_reg[c*MAX_WORD_BITS +: MAX_WORD_BITS] <=
            {pipe_reg[PIPE_LATENCY-1][c*SAMPLE_BITS+SAMPLE_BITS-1] ^ ~twos_l,
             pipe_reg[PIPE_LATENCY-1][c*SAMPLE_BITS +: SAMPLE_BITS-1], 2'h0};
        bit_cnt_reg <= 5'h0;
        odd_reg     <= ~odd_reg;
        frame_cnt_reg  <= frame_cnt_reg + 2'h1;
        frame_gray_reg <= (frame_cnt_reg + 2'h1) ^ ((frame_cnt_reg + 2'h1) >> 1);
      end
      else if (bit_cnt_reg < lane_bits)
      begin
        for (int c = 0; c < CH; c++)
        begin
          lane_a_out[c] <= word_reg[c*MAX_WORD_BITS + MAX_WORD_BITS - 1];
          lane_b_out[c] <= two_lane_l ? word_reg[c*MAX_WORD_BITS + MAX_WORD_BITS - 2] : 1'b0;
          word_reg[c*MAX_WORD_BITS +: MAX_WORD_BITS] <= two_lane_l ?
            {word_reg[c*MAX_WORD_BITS +: MAX_WORD_BITS-2], 2'h0} :
            {word_reg[c*MAX_WORD_BITS +: MAX_WORD_BITS-1], 1'b0};
        end
        bit_cnt_reg <= bit_cnt_reg + 5'h1;
        // mark stands over the first bit; in 14-bit two-lane it stands over every bit of each second word
        frame_start_out <= frame_pair ? odd_reg : (bit_cnt_reg == 5'h0);
      end
    end
  end

  // frame count to system domain, gray coded
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      frame_gray_s1_reg  <= 2'h0;
      frame_gray_s2_reg  <= 2'h0;
      frame_cnt_sync_reg <= 2'h0;
    end
    else if (clk_en)
    begin
      frame_gray_s1_reg  <= frame_gray_reg;
      frame_gray_s2_reg  <= frame_gray_s1_reg;
      frame_cnt_sync_reg <= {frame_gray_s2_reg[1], ^frame_gray_s2_reg};
    end
  end

endmodule

// *** adc_serial_framing_assertions.sv ***
`timescale 1ns/100ps
module adc_serial_framing_assertions
  import serial_framing_pkg::*;
#(
  parameter int CH = CHANNELS
)
(
  // clocks and reset
  input wire logic          sys_clk,
  input wire logic          link_clk,
  input wire logic          nrst,
  // register port
  input wire logic          reg_rd,
  input wire logic [3:0]    reg_addr,
  input wire logic [15:0]   reg_rdata,
  // link side
  input wire logic [CH-1:0] lane_b_enable,
  input wire logic          frame_start_out,
  input wire logic          serial_bit_clock_out,
  // serial config
  input wire logic          cfg_cs_n,
  input wire logic          cfg_sck,
  input wire logic          config_readback_out,
  input wire logic          config_readback_oe
);
  sequence frame_quiet;
    !frame_start_out [*5];
  endsequence
  AST_BIT_CLOCK: assert property (@(posedge link_clk) disable iff (!nrst)
    $past(nrst, 3) |-> serial_bit_clock_out != $past(serial_bit_clock_out))
    else $error("bit clock stalled");
  AST_FRAME_MARK: assert property (@(posedge link_clk) disable iff (!nrst)
    $rose(frame_start_out) |=> frame_quiet) else $error("frame mark too long");
  AST_LANE_B: assert property (@(posedge link_clk) disable iff (!nrst)
    lane_b_enable == '0 || lane_b_enable == '1) else $error("lane b enables split");
  AST_RB_LOW: assert property (@(posedge sys_clk) disable iff (!nrst)
    config_readback_out == 1'b0) else $error("readback driven high");
  AST_RB_EDGE: assert property (@(posedge sys_clk) disable iff (!nrst)
    $changed(config_readback_oe) && !cfg_cs_n && !$past(cfg_cs_n, 4) |-> !cfg_sck)
    else $error("readback moved with clock high");
  AST_RD_IDLE: assert property (@(posedge sys_clk) disable iff (!nrst)
    !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray read data");
  AST_RD_UNMAPPED: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(reg_rd) && $past(reg_addr) == 4'hf |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_STATUS: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(reg_rd) && $past(reg_addr) == OFS_STATUS |-> reg_rdata[15:2] == 14'h0000)
    else $error("status upper bits set");
endmodule
bind adc_serial_framing adc_serial_framing_assertions #(.CH(CH)) chk (.sys_clk, .link_clk,
  .nrst, .reg_rd, .reg_addr, .reg_rdata, .lane_b_enable, .frame_start_out,
  .serial_bit_clock_out, .cfg_cs_n, .cfg_sck, .config_readback_out, .config_readback_oe);

// *** adc_serial_framing_tb_top.sv ***
`timescale 1ns/100ps
module adc_serial_framing_tb_top;
  import serial_framing_pkg::*;
  logic        sys_clk = 1'b0, link_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1;
  logic        programming_style_select = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        sample_clock_in = 1'b0, cfg_cs_n = 1'b1, cfg_sck = 1'b0, config_serial_in = 1'b0;
  logic        frame_start_out, serial_bit_clock_out, config_readback_out, config_readback_oe;
  logic [3:0]  reg_addr = 4'h0, lane_a_out, lane_b_out, lane_b_enable;
  logic [4:0]  sdiv = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, word, w0, w1;
  logic [CHANNELS*SAMPLE_BITS-1:0] sample_in = '0;
  int          miscompares = 0;
  int          n_compared = 0;
  always #25 sys_clk = ~sys_clk;
  always #62.5 link_clk = ~link_clk;
  always @(posedge sys_clk)
  begin
    sdiv <= (sdiv == 5'h17) ? 5'h00 : sdiv + 5'h01;
    if (sdiv == 5'h17) sample_clock_in <= ~sample_clock_in;
  end
  adc_serial_framing dut (.sys_clk, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .link_clk, .sample_clock_in, .sample_in, .lane_a_out, .lane_b_out,
    .lane_b_enable, .frame_start_out, .serial_bit_clock_out, .programming_style_select,
    .cfg_cs_n, .cfg_sck, .config_serial_in, .config_readback_out, .config_readback_oe);
  lane_receiver #(.NB(14)) rx (.link_clk, .frame_start_out, .lane_in(lane_a_out[0]), .word);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m = 16'hffff);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, exp);
    @(posedge sys_clk);
  endtask
  task automatic spi(input logic [7:0] b);
    cfg_cs_n <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      config_serial_in <= b[i];
      repeat (8) @(posedge sys_clk);
      cfg_sck <= 1'b1;
      repeat (8) @(posedge sys_clk);
      cfg_sck <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    cfg_cs_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic grab(input logic [13:0] s, output logic [15:0] w);
    sample_in <= {CHANNELS{s}};
    repeat (600) @(posedge sys_clk);
    w = word;
  endtask
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rd(OFS_CONFIG, {11'h000, CFG_RESET});
    chk({12'h000, lane_b_enable}, 16'h000f);
    rd(4'hf, 16'h0000);
    wr(4'hf, 16'h001f);
    rd(OFS_CONFIG, 16'h0005);
    rd(OFS_STATUS, 16'h0000, 16'hfffc);
    $display("test reset and unmapped done");
    spi(8'h08);
    rd(OFS_CONFIG, 16'h0008);
    repeat (20) @(posedge sys_clk);
    chk({12'h000, lane_b_enable}, 16'h0000);
    $display("test serial config done");
    grab(14'h0000, w0);
    grab(14'h3fff, w1);
    chk(w0 ^ w1, 16'h3fff);
    wr(OFS_CONFIG, 16'h000a);
    grab(14'h0000, w1);
    chk(w0 ^ w1, 16'h2000);
    $display("test data format done");
    end_sim;
  end
  initial
  begin
    #500000;
    miscompares++;
    end_sim;
  end
endmodule

// *** lane_receiver.sv ***
`timescale 1ns/100ps
module lane_receiver #(
  parameter int NB = 14
)
(
  // link side
  input wire logic link_clk,
  input wire logic frame_start_out,
  input wire logic lane_in,
  // collected word
  output logic [15:0] word
);
  logic [15:0] shift_reg = '0;
  int          cnt = 0;
  // bit per clock, word from mark
  always @(posedge link_clk)
  begin
    if (frame_start_out || (cnt > 0 && cnt < NB))
    begin
      shift_reg = frame_start_out ? {15'h0000, lane_in} : {shift_reg[14:0], lane_in};
      cnt = frame_start_out ? 1 : cnt + 1;
    end
    if (cnt == NB)
    begin
      word <= shift_reg;
      cnt = 0;
    end
  end
endmodule

// *** serial_framing_pkg.sv ***
package serial_framing_pkg;

  // serialization word-width modes
  typedef enum logic [1:0] {
    ser_16_type_val = 2'h0,
    ser_14_type_val = 2'h1,
    ser_12_type_val = 2'h2
  } ser_mode_type;

  typedef struct packed {
    logic       two_lane;
    logic       twos_comp;
    logic       dcs_enable;
    logic [1:0] ser_mode;
  } cfg_type;

  localparam int  CHANNELS        = 4;
  localparam int  SAMPLE_BITS     = 14;
  localparam int  PIPE_LATENCY    = 6;
  localparam int  MAX_WORD_BITS   = 16;

  // register offsets on the software port
  localparam logic [3:0] OFS_CONFIG  = 4'h0;
  localparam logic [3:0] OFS_STATUS  = 4'h1;
  localparam logic [3:0] OFS_SAMPLE0 = 4'h2;

  // config field positions
  localparam int  CFG_TWO_LANE_BIT  = 0;
  localparam int  CFG_TWOS_BIT      = 1;
  localparam int  CFG_DCS_BIT       = 2;
  localparam int  CFG_MODE_LSB      = 3;
  localparam logic [4:0] CFG_RESET  = 5'h05;

  // serial config port
  localparam int  CFG_SHIFT_BITS = 8;

  // lane bit-rate ceiling and encode clock phase minimums
  localparam real MIN_LANE_BIT_PERIOD_NS = 1.0;
  localparam real MIN_ENC_PHASE_DCS_NS   = 2.0;
  localparam real MIN_ENC_PHASE_NODCS_NS = 3.8;

endpackage
